//--- design/acso_ctrl.sv
// Convert-start sequencing, track-and-hold control and overtemperature flag.
// Assumes the channel and setpoint come from configuration logic on this
// clock, the converter code is valid when the conversion time has run, and
// the convert-start pin is asynchronous.
`timescale 1ns/1ps

// Contract
// [R1] Rising start edge powers up for 4 us.
// [R2] Long pulse: hold and convert at falling edge.
// [R3] Short pulse: timer delays hold until powered.
// [R4] End of conversion returns to track.
// [R5] Channel 0 result above setpoint sets flag.
// [R6] Serial read end clears open-drain flag.
// [R7] Host selects channel 4 for external input.
// [R8] Host waits acquisition time before next start.
// [R9] Acquisition time is 400 ns.
// [R10] Result after 15 us, or 30 us temperature.
// [R11] Start edges during conversion are ignored.
module acso_ctrl (
  // Clock and reset
  input  wire logic                           clock_i,
  input  wire logic                           nrst_i,
  // Convert-start pin
  input  wire logic                           convert_start_pulse_i,
  // Configuration and serial interface
  input  wire logic [acso_pkg::CH_W-1:0]      channel_sel_i,
  input  wire logic [acso_pkg::SETP_W-1:0]    over_temp_setpoint_i,
  input  wire logic                           serial_read_done_i,
  // Converter core
  input  wire logic [acso_pkg::RES_W-1:0]     adc_code_i,
  output logic                                power_up_o,
  output logic                                hold_o,
  output logic                                conv_done_o,
  output logic [acso_pkg::RES_W-1:0]          result_o,
  output logic [acso_pkg::CH_W-1:0]           result_chan_o,
  // Overtemperature pin, open drain
  input  wire logic                           over_temp_flag_i,
  output logic                                over_temp_flag_o,
  output logic                                over_temp_flag_oe_o
);
  import acso_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchroniser and edge detection
  // ---------------------------------------------------------------
  logic cs_s1, cs_s2, cs_s3;
  logic cs_rise, cs_fall;

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      cs_s1 <= 1'b0;
      cs_s2 <= 1'b0;
      cs_s3 <= 1'b0;
    end else begin
      cs_s1 <= convert_start_pulse_i;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
    end
  end

  assign cs_rise = cs_s2 & ~cs_s3;
  assign cs_fall = ~cs_s2 & cs_s3;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  acso_timer_if tif ();

  acso_timer u_timer (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .tif     (tif)
  );

  acso_state_t      state, next_state;
  logic             fell_seen, next_fell_seen;
  logic [CH_W-1:0]  chan, next_chan;
  logic             next_power_up, next_hold, next_done;
  logic [RES_W-1:0] next_result;
  logic [CH_W-1:0]  next_result_chan;
  logic             flag, next_flag;
  logic             capture;
  logic             temp_over;

  // Signed whole-degree compare against the signed setpoint.
  assign temp_over = $signed(adc_code_i[RES_W-1:DEG_LSB]) > $signed(over_temp_setpoint_i);

  always_comb begin
    next_state     = state;
    next_fell_seen = fell_seen;
    next_chan      = chan;
    next_power_up  = power_up_o;
    next_hold      = hold_o;
    next_done      = 1'b0;
    next_result    = result_o;
    next_result_chan = result_chan_o;
    capture        = 1'b0;
    tif.start      = 1'b0;
    tif.load       = PU_CYCLES;
    case (state)
      ACSO_IDLE: begin
        if (cs_rise) begin
          next_state     = ACSO_PWRUP;                           // R1
          next_power_up  = 1'b1;                                 // R1
          next_fell_seen = 1'b0;
          tif.start      = 1'b1;                                 // R1
        end
      end
      ACSO_PWRUP: begin
        if (cs_fall) begin
          next_fell_seen = 1'b1;                                 // R3
        end
        if (tif.expired) begin
          if (fell_seen || cs_fall) begin
            next_state = ACSO_CONVERT;                           // R3
            next_hold  = 1'b1;                                   // R3
            next_chan  = channel_sel_i;
            tif.start  = 1'b1;
            tif.load   = (channel_sel_i == CH_TEMP) ? TEMP_CYCLES : AIN_CYCLES; // R10
          end else begin
            next_state = ACSO_WAIT_LO;
          end
        end
      end
      ACSO_WAIT_LO: begin
        if (cs_fall) begin
          next_state = ACSO_CONVERT;                             // R2
          next_hold  = 1'b1;                                     // R2
          next_chan  = channel_sel_i;
          tif.start  = 1'b1;
          tif.load   = (channel_sel_i == CH_TEMP) ? TEMP_CYCLES : AIN_CYCLES; // R10
        end
      end
      ACSO_CONVERT: begin
        // Edges here are deliberately dropped so the running result stays intact.
        if (tif.expired) begin                                   // R11
          next_state    = ACSO_IDLE;
          next_hold     = 1'b0;                                  // R4
          next_power_up = 1'b0;
          next_done     = 1'b1;                                  // R10
          next_result   = adc_code_i;                            // R10
          next_result_chan = chan;                               // R10
          capture       = 1'b1;
        end
      end
      default: begin
        next_state = ACSO_IDLE;
      end
    endcase
  end

  // A new excursion wins over a serial read landing in the same cycle.
  always_comb begin
    next_flag = flag;
    if (serial_read_done_i) begin
      next_flag = 1'b0;                                          // R6
    end
    if (capture && chan == CH_TEMP && temp_over) begin
      next_flag = 1'b1;                                          // R5
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      state               <= ACSO_IDLE;
      fell_seen           <= 1'b0;
      chan                <= RST_CHAN;
      power_up_o          <= 1'b0;
      hold_o              <= 1'b0;
      conv_done_o         <= 1'b0;
      result_o            <= RST_RESULT;
      result_chan_o       <= RST_CHAN;
      flag                <= 1'b0;
      over_temp_flag_o    <= 1'b0;
      over_temp_flag_oe_o <= 1'b0;
    end else begin
      state               <= next_state;
      fell_seen           <= next_fell_seen;
      chan                <= next_chan;
      power_up_o          <= next_power_up;
      hold_o              <= next_hold;
      conv_done_o         <= next_done;
      result_o            <= next_result;
      result_chan_o       <= next_result_chan;
      flag                <= next_flag;
      over_temp_flag_o    <= 1'b0;                               // R6
      over_temp_flag_oe_o <= next_flag;                          // R6
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic [TMR_W-1:0] pu_age;
  logic [TMR_W-1:0] hold_age;

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      pu_age   <= '0;
      hold_age <= '0;
    end else begin
      pu_age   <= power_up_o ? pu_age + TMR_W'(1) : '0;
      hold_age <= hold_o ? hold_age + TMR_W'(1) : '0;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  powerup_start_a: assert property ( // R1
    state == ACSO_IDLE && cs_rise |=> power_up_o && !hold_o)
    else $error("power-up not started on rising start edge");

  hold_on_fall_a: assert property ( // R2
    state == ACSO_WAIT_LO && cs_fall |=> hold_o && state == ACSO_CONVERT)
    else $error("hold not entered on falling start edge");

  hold_after_pu_a: assert property ( // R3
    $rose(hold_o) |-> pu_age >= PU_CYCLES)
    else $error("hold entered before power-up time");

  pu_exact_a: assert property ( // R3
    state == ACSO_PWRUP && fell_seen && tif.expired |=> $rose(hold_o) && pu_age == PU_CYCLES)
    else $error("short pulse did not convert right after power-up");

  track_at_end_a: assert property ( // R4
    conv_done_o |-> !hold_o && $past(hold_o))
    else $error("track mode not resumed at end of conversion");

  flag_set_a: assert property ( // R5
    capture && chan == CH_TEMP && temp_over |=> over_temp_flag_oe_o && !over_temp_flag_o)
    else $error("overtemperature flag not set");

  flag_clear_a: assert property ( // R6
    serial_read_done_i && !capture |=> !over_temp_flag_oe_o)
    else $error("overtemperature flag not cleared by serial read");

  temp_time_a: assert property ( // R10
    $fell(hold_o) && result_chan_o == CH_TEMP |-> $past(hold_age) == TEMP_CYCLES - TMR_W'(1)
      && hold_age == TEMP_CYCLES)
    else $error("temperature conversion length wrong");

  ain_time_a: assert property ( // R10
    $fell(hold_o) && result_chan_o != CH_TEMP |-> hold_age == AIN_CYCLES)
    else $error("input conversion length wrong");

  no_restart_a: assert property ( // R11
    state == ACSO_CONVERT && !tif.expired && (cs_fall || cs_rise) |=> hold_o && !conv_done_o)
    else $error("start edge disturbed a running conversion");

  short_pulse_c: cover property (state == ACSO_PWRUP && cs_fall ##1 fell_seen);
  long_pulse_c:  cover property (state == ACSO_WAIT_LO && cs_fall);
  flag_set_c:    cover property ($rose(over_temp_flag_oe_o));
  set_clear_c:   cover property (capture && serial_read_done_i);

endmodule : acso_ctrl

//--- shared/acso_pkg.sv
// Constants shared by the converter start and overtemperature control.
// Assumes a single 25 MHz clock and a synchronous, active-low reset.
package acso_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned PU_TIME_NS    = 4000;
  localparam int unsigned AIN_CONV_NS   = 15000;
  localparam int unsigned TEMP_CONV_NS  = 30000;
  // The far side must leave this much track time between conversions.
  localparam int unsigned ACQ_TIME_NS   = 400;

  localparam int unsigned TMR_W = 10;

  // Least times round up to whole cycles.
  localparam logic [TMR_W-1:0] PU_CYCLES   =
    TMR_W'((PU_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] AIN_CYCLES  =
    TMR_W'((AIN_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] TEMP_CYCLES =
    TMR_W'((TEMP_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] ACQ_CYCLES  =
    TMR_W'((ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // Channels, data layout and reset values
  // ---------------------------------------------------------------
  localparam int unsigned     CH_W      = 3;
  localparam logic [CH_W-1:0] CH_TEMP   = 3'h0;
  localparam logic [CH_W-1:0] CH_AIN    = 3'h4;
  localparam int unsigned     RES_W     = 10;
  localparam int unsigned     SETP_W    = 8;
  // Whole-degree part of the temperature code sits in the top bits.
  localparam int unsigned     DEG_LSB   = 2;
  localparam logic [RES_W-1:0] RST_RESULT = 10'h000;
  localparam logic [CH_W-1:0]  RST_CHAN   = 3'h0;

  typedef enum logic [1:0] {
    ACSO_IDLE    = 2'h0,
    ACSO_PWRUP   = 2'h1,
    ACSO_WAIT_LO = 2'h3,
    ACSO_CONVERT = 2'h2
  } acso_state_t;

endpackage : acso_pkg

//--- shared/acso_timer_if.sv
// Handshake between the sequencer and its shared down-counting timer.
// Both ends run on the same clock.
`timescale 1ns/1ps
interface acso_timer_if;
  logic                       start;
  logic [acso_pkg::TMR_W-1:0] load;
  logic                       expired;

  modport ctrl  (output start, output load, input expired);
  modport timer (input start, input load, output expired);
endinterface : acso_timer_if

//--- design/acso_timer.sv
// One-shot down counter: a start loads a length of N cycles, and expired
// is high in the last of those N cycles. Same clock as the sequencer.
`timescale 1ns/1ps
module acso_timer (
  // Clock and reset
  input  wire logic   clock_i,
  input  wire logic   nrst_i,
  // Sequencer side
  acso_timer_if.timer tif
);
  import acso_pkg::*;

  logic [TMR_W-1:0] cnt;
  logic [TMR_W-1:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (tif.start) begin
      next_cnt = tif.load;
    end else if (cnt != '0) begin
      next_cnt = cnt - TMR_W'(1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign tif.expired = (cnt == TMR_W'(1));

endmodule : acso_timer

//--- dv/acso_host_model.sv
// Host-side model: drives the convert-start pin and the channel choice.
// Assumes the bench clock and the design's one-cycle end-of-conversion pulse.
`timescale 1ns/1ps
module acso_host_model (
  // Clock and design feedback
  input  wire logic                      clock_i,
  input  wire logic                      conv_done_i,
  // Pins towards the design
  output logic                           convert_start_pulse_o,
  output logic [acso_pkg::CH_W-1:0]      channel_sel_o
);
  import acso_pkg::*;
  int idle = 1000;

  initial begin
    convert_start_pulse_o = 1'b0;
    channel_sel_o         = CH_AIN;
  end

  always @(posedge clock_i) begin
    idle <= conv_done_i ? 0 : idle + 1;
  end

  task automatic set_channel(input logic [CH_W-1:0] ch);
    channel_sel_o = ch;
  endtask : set_channel

  // A start too soon after a conversion would sample an unsettled input.
  task automatic pulse(input int len, input bit wait_acq);
    while (wait_acq && idle < int'(ACQ_CYCLES)) @(negedge clock_i);
    convert_start_pulse_o = 1'b1;
    repeat (len) @(negedge clock_i);
    convert_start_pulse_o = 1'b0;
  endtask : pulse
endmodule : acso_host_model

//--- dv/adc_convert_start_overtemp_tb_top.sv
// Self-checking bench for the convert-start and overtemperature control.
// Assumes the design's stated latencies; inputs change on falling edges.
`timescale 1ns/1ps
module adc_convert_start_overtemp_tb_top;
  import acso_pkg::*;
  logic              clock_i = 1'b0;
  logic              nrst_i  = 1'b0;
  logic              serial_read_done_i = 1'b0;
  logic [SETP_W-1:0] over_temp_setpoint_i = 8'h19;
  logic [RES_W-1:0]  adc_code_i = 10'h000;
  logic              convert_start_pulse_i;
  logic [CH_W-1:0]   channel_sel_i;
  logic              power_up_o;
  logic              hold_o;
  logic              conv_done_o;
  logic [RES_W-1:0]  result_o;
  logic [CH_W-1:0]   result_chan_o;
  logic              over_temp_flag_o;
  logic              over_temp_flag_oe_o;
  wire               flag_pin = over_temp_flag_oe_o ? over_temp_flag_o : 1'b1;
  int                fail_count = 0;
  int                checks = 0;
  int                tp;
  int                th;
  int                tl;

  initial begin
    forever #20 clock_i = ~clock_i;
  end

  acso_ctrl dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .convert_start_pulse_i(convert_start_pulse_i),
    .channel_sel_i(channel_sel_i), .over_temp_setpoint_i(over_temp_setpoint_i),
    .serial_read_done_i(serial_read_done_i), .adc_code_i(adc_code_i),
    .power_up_o(power_up_o), .hold_o(hold_o), .conv_done_o(conv_done_o),
    .result_o(result_o), .result_chan_o(result_chan_o), .over_temp_flag_i(flag_pin),
    .over_temp_flag_o(over_temp_flag_o), .over_temp_flag_oe_o(over_temp_flag_oe_o)
  );

  acso_host_model host (
    .clock_i(clock_i), .conv_done_i(conv_done_o),
    .convert_start_pulse_o(convert_start_pulse_i), .channel_sel_o(channel_sel_i)
  );

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d, fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  // Times are falling edges counted from the pulse rise, the hold length from hold rise; a glitch is a
  // second pulse fired that many cycles into hold. Hot is the flag state
  // expected once the conversion has ended.
  task automatic convert(input int len, input logic [CH_W-1:0] ch,
                         input logic [RES_W-1:0] code, input bit hot, input int glitch,
                         output int t_pu, output int t_hold, output int t_len);
    int  n;
    repeat (12) @(negedge clock_i);
    host.set_channel(ch);
    adc_code_i = code;
    n = 0;
    t_len = 0;
    fork
      host.pulse(len, 1'b1);
      begin
        while (!power_up_o && n < 20) begin @(negedge clock_i); n++; end
        t_pu = n;
        while (!hold_o && n < 400) begin @(negedge clock_i); n++; end
        t_hold = n;
        while (hold_o && t_len < 1000) begin
          @(negedge clock_i);
          t_len++;
          if (glitch != 0 && t_len == glitch) fork host.pulse(3, 1'b0); join_none
        end
      end
    join
    chk("conv_done", 1, conv_done_o);
    chk("power_up_end", 0, power_up_o);
    chk("result", 32'(code), 32'(result_o));
    chk("result_chan", 32'(ch), 32'(result_chan_o));
    chk("flag_oe", 32'(hot), 32'(over_temp_flag_oe_o));
    chk("flag_data", 0, over_temp_flag_o);
  endtask : convert

  task automatic test_long_ain();
    convert(150, CH_AIN, 10'h3F0, 1'b0, 0, tp, th, tl);
    chk("power_up_delay", 3, tp);
    chk("hold_at_fall", 153, th);
    chk("ain_hold_len", 32'(AIN_CYCLES), tl);
  endtask : test_long_ain

  task automatic test_short_temp();
    convert(5, CH_TEMP, 10'h078, 1'b1, 0, tp, th, tl);
    chk("hold_after_pwrup", 32'(tp + int'(PU_CYCLES)), th);
    chk("temp_hold_len", 32'(TEMP_CYCLES), tl);
    repeat (5) @(negedge clock_i);
    chk("flag_pin_held", 0, flag_pin);
  endtask : test_short_temp

  // A serial read in the capture cycle of a hot result loses to the new set.
  task automatic test_set_wins();
    fork
      convert(5, CH_TEMP, 10'h078, 1'b1, 0, tp, th, tl);
      begin
        @(posedge hold_o);
        @(negedge clock_i);
        repeat (int'(TEMP_CYCLES) - 1) @(negedge clock_i);
        serial_read_done_i = 1'b1;
        @(negedge clock_i);
        serial_read_done_i = 1'b0;
      end
    join
    @(negedge clock_i);
    chk("flag_set_wins", 1, over_temp_flag_oe_o);
  endtask : test_set_wins

  task automatic test_read_clear();
    serial_read_done_i = 1'b1;
    @(negedge clock_i);
    serial_read_done_i = 1'b0;
    chk("flag_cleared", 0, over_temp_flag_oe_o);
    chk("flag_pin_idle", 1, flag_pin);
  endtask : test_read_clear

  // Equal to the setpoint, and a negative code with large raw bits.
  task automatic test_no_flag();
    logic [RES_W-1:0] codes [2];
    codes = '{10'h064, 10'h3FC};
    foreach (codes[i]) convert(5, CH_TEMP, codes[i], 1'b0, 0, tp, th, tl);
  endtask : test_no_flag

  task automatic test_retrigger();
    convert(150, CH_AIN, 10'h155, 1'b0, 50, tp, th, tl);
    chk("hold_len_retrig", 32'(AIN_CYCLES), tl);
    repeat (20) @(negedge clock_i);
    chk("no_new_pwrup", 0, power_up_o);
    chk("no_new_hold", 0, hold_o);
  endtask : test_retrigger

  // Reset held three edges in mid-conversion must drop hold, power-up, done, result and result channel at once.
  task automatic test_mid_reset();
    repeat (12) @(negedge clock_i);
    fork host.pulse(5, 1'b1); join_none
    repeat (200) @(negedge clock_i);
    chk("hold_before_reset", 1, hold_o);
    nrst_i = 1'b0;
    repeat (3) @(negedge clock_i);
    chk("reset_mid_hold", 0, hold_o);
    chk("reset_mid_pwrup", 0, power_up_o);
    chk("reset_mid_done", 0, conv_done_o);
    chk("reset_mid_result", 32'(RST_RESULT), 32'(result_o));
    chk("reset_mid_chan", 32'(RST_CHAN), 32'(result_chan_o));
    nrst_i = 1'b1;
    repeat (20) @(negedge clock_i);
    chk("after_reset_pwrup", 0, power_up_o);
    chk("after_reset_hold", 0, hold_o);
  endtask : test_mid_reset

  initial begin
    repeat (12) @(negedge clock_i);
    chk("reset_pwrup", 0, power_up_o);
    chk("reset_hold", 0, hold_o);
    chk("reset_flag", 0, over_temp_flag_oe_o);
    chk("reset_result", 32'(RST_RESULT), 32'(result_o));
    nrst_i = 1'b1;
    test_long_ain();
    test_short_temp();
    test_set_wins();
    test_read_clear();
    test_no_flag();
    test_retrigger();
    test_mid_reset();
    end_of_test();
  end

  // Six conversions of at most 900 cycles and one cut conversion fit well
  // inside this span.
  initial begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    $display("unexpected watchdog: expected finish, seen timeout");
    end_of_test();
  end
endmodule : adc_convert_start_overtemp_tb_top
